// File: ashc_pkg.sv
// Purpose: Constants for the automatic serial handshake controller
// Assumes: Register bus with 8-bit index-free byte offsets, 8-bit data
// Notes:   Operation summary follows
//
// Operation
// - Shift register write only starts, loads buffer
// - After each byte, decrement pointer, load next
// - Repetitive mode: no done flag, reload pointer
// - Unit off: finish current byte, then stop
// - On stop clear active, pins to port
// - Unit on plus trigger resumes remaining data
// - Halt freezes transfer mid-byte, resumes exactly
// - Busy waiting needs auto mode and wait enable
// - Busy sampled on falls, never pauses byte
// - Busy at second rise after byte holds off
// - Polarity bit zero high, one low active
// - Gap time control enabled disables busy waiting
// - Data output low while not active
// - Inactive busy sample starts byte next fall
// - Auto mode plus strobe enable pulses strobe
// - Done flag set at second rise after last byte, with or without strobe
// - With busy waiting enabled, any active busy sample in byte flags error
// - Repetitive mode when reload one, receive zero
// - Clock select one internal, zero external clock
package ashc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_AUTO    = 8'h04;
  localparam logic [7:0] OFS_GAP     = 8'h08;
  localparam logic [7:0] OFS_PTR     = 8'h0C;
  localparam logic [7:0] OFS_SHIFT   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_BUF     = 8'h80;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_UNIT_ON   = 7;
  localparam int BIT_AUTO_ON   = 5;
  localparam int BIT_CLK_SRC   = 1;
  localparam int BIT_WAIT_POL  = 0;
  localparam int BIT_WAIT_ON   = 1;
  localparam int BIT_PULSE_ON  = 2;
  localparam int BIT_ACTIVE    = 3;
  localparam int BIT_ERR       = 4;
  localparam int BIT_RELOAD    = 5;
  localparam int BIT_RX_ON     = 6;
  localparam int BIT_GAP_ON    = 7;
  localparam int BIT_DONE      = 0;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_AUTO  = 8'h00;
  localparam logic [7:0] RST_GAP   = 8'h00;
  localparam logic [4:0] RST_PTR   = 5'h00;
  localparam int         GAP_W     = 5;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [1:0] POST_RISE = 2'h2;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_POST  = 3'b011,
    ST_BUSY  = 3'b100
  } ashc_state_e;

endpackage

// File: ashc_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Destination is the core clock domain
// Notes:   First stage is read by the second only
`timescale 1ns/1ps
module ashc_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// File: ashc_ctrl.sv
// Purpose: Automatic byte transmitter with busy, strobe and mid-byte busy error check
// Assumes: Core clock 200 MHz; serial pins asynchronous to it
// Notes:   Buffer is transmitted from the pointer down to index zero
`timescale 1ns/1ps
module ashc_ctrl
  import ashc_pkg::*;
#(
  parameter int              DEPTH   = 32,
  parameter logic [7:0]      HALF_DIV = 8'h08
)
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Power state
  input  wire logic       i_halt,
  // Serial clock pin
  input  wire logic       i_serial_clk_pin,
  output logic            o_serial_clk_pin,
  output logic            o_serial_clk_oe,
  // Serial data and handshake pins
  output logic            o_serial_out_pin,
  output logic            o_serial_out_oe,
  output logic            o_pulse_out_pin,
  output logic            o_pulse_out_oe,
  input  wire logic       i_busy_pin,
  output logic            o_port_mode,
  // Completion event
  output logic            o_xfer_done_irq
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int PW = $clog2(DEPTH);

  logic [7:0]    serial_mode_reg_r;
  logic [7:0]    auto_ctrl_reg_r;
  logic [7:0]    gap_time_reg_r;
  logic [PW-1:0] buf_ptr_r;
  logic [PW-1:0] start_ptr_r;
  logic [7:0]    buf_mem_r [DEPTH];
  logic [7:0]    shift_reg_r;
  logic          xfer_active_r;
  logic          xfer_done_flag_r;
  logic          err_r;
  logic          resume_pend_r;
  ashc_state_e   state_r;
  logic [2:0]    bit_cnt_r;
  logic [1:0]    post_cnt_r;
  logic [GAP_W:0] gap_cnt_r;
  logic          busy_seen_r;
  logic [7:0]    div_cnt_r;
  logic          int_phase_r;
  logic          ext_prev_r;
  logic [1:0]    pins_sync;
  logic          fall_e;
  logic          rise_e;
  logic          wr_shift;
  logic          busy_act;
  logic          busy_en;
  logic          repeat_mode;
  logic          byte_end;
  logic          post_end;
  logic          gap_ok;
  logic          done_set;

  // Buffer index decode
  function automatic logic buf_hit(input logic [7:0] a);
    return (a >= OFS_BUF) && ({1'b0, a} < ({1'b0, OFS_BUF} + 9'(DEPTH * 4)))
           && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [PW-1:0] buf_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_BUF;
    return d[PW+1:2];
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  ashc_sync #(.W(2)) u_sync
  (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_busy_pin, i_serial_clk_pin}),
    .o_sync     (pins_sync)
  );

  // ****************************************
  // Serial clock edges
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_cnt_r   <= 8'h00;
      int_phase_r <= 1'b1;
      ext_prev_r  <= 1'b1;
    end
    else if (!i_halt)
    begin
      ext_prev_r <= pins_sync[0];
      if (div_cnt_r >= HALF_DIV - 8'h01)
      begin
        div_cnt_r   <= 8'h00;
        int_phase_r <= ~int_phase_r;
      end
      else
      begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  always_comb
  begin
    if (serial_mode_reg_r[BIT_CLK_SRC])
    begin
      fall_e = !i_halt && (div_cnt_r >= HALF_DIV - 8'h01) && int_phase_r;
      rise_e = !i_halt && (div_cnt_r >= HALF_DIV - 8'h01) && !int_phase_r;
    end
    else
    begin
      fall_e = !i_halt && ext_prev_r && !pins_sync[0];
      rise_e = !i_halt && !ext_prev_r && pins_sync[0];
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  assign wr_shift    = i_wr && (i_addr == OFS_SHIFT);
  assign busy_act    = pins_sync[1] ^ auto_ctrl_reg_r[BIT_WAIT_POL];
  assign busy_en     = serial_mode_reg_r[BIT_AUTO_ON] && auto_ctrl_reg_r[BIT_WAIT_ON]
                       && !gap_time_reg_r[BIT_GAP_ON];
  assign repeat_mode = auto_ctrl_reg_r[BIT_RELOAD] && !auto_ctrl_reg_r[BIT_RX_ON];
  assign byte_end    = (state_r == ST_SHIFT) && rise_e && (bit_cnt_r == LAST_BIT);
  assign post_end    = (state_r == ST_POST) && rise_e && (post_cnt_r == POST_RISE - 2'h1);
  assign gap_ok      = !gap_time_reg_r[BIT_GAP_ON]
                       || (gap_cnt_r >= {1'b0, gap_time_reg_r[GAP_W-1:0]});
  assign done_set    = post_end && busy_seen_r;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      serial_mode_reg_r <= RST_MODE;
      auto_ctrl_reg_r   <= RST_AUTO;
      gap_time_reg_r    <= RST_GAP;
    end
    else if (i_wr)
    begin
      case (i_addr)
        OFS_MODE: serial_mode_reg_r <= i_wdata;
        OFS_AUTO: auto_ctrl_reg_r   <= i_wdata;
        OFS_GAP:  gap_time_reg_r    <= i_wdata;
        default:  serial_mode_reg_r <= serial_mode_reg_r;
      endcase
    end
  end

  // Buffer storage
  always_ff @(posedge i_core_clk)
  begin
    if (i_wr && buf_hit(i_addr))
    begin
      buf_mem_r[buf_idx(i_addr)] <= i_wdata;
    end
  end

  // ****************************************
  // Transfer engine
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r       <= ST_IDLE;
      buf_ptr_r     <= RST_PTR;
      start_ptr_r   <= RST_PTR;
      shift_reg_r   <= 8'h00;
      bit_cnt_r     <= 3'h0;
      post_cnt_r    <= 2'h0;
      gap_cnt_r     <= '0;
      xfer_active_r <= 1'b0;
      resume_pend_r <= 1'b0;
      busy_seen_r   <= 1'b0;
    end
    else if (!i_halt)
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (i_wr && i_addr == OFS_PTR)
          begin
            buf_ptr_r     <= i_wdata[PW-1:0];
            resume_pend_r <= 1'b0;
          end
          else if (wr_shift && serial_mode_reg_r[BIT_UNIT_ON])
          begin
            if (!resume_pend_r)
            begin
              start_ptr_r <= buf_ptr_r;
            end
            resume_pend_r <= 1'b0;
            xfer_active_r <= 1'b1;
            state_r       <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          shift_reg_r <= buf_mem_r[buf_ptr_r];
          bit_cnt_r   <= 3'h0;
          busy_seen_r <= 1'b0;
          // With internal clock, wait so the first serial event of a byte is a fall; external clock enters shift at once
          if (!serial_mode_reg_r[BIT_CLK_SRC] || rise_e || (int_phase_r && !fall_e))
          begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (fall_e)
          begin
            shift_reg_r <= {shift_reg_r[6:0], 1'b0};
          end
          if (rise_e)
          begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
          end
          if (byte_end)
          begin
            post_cnt_r <= 2'h0;
            gap_cnt_r  <= '0;
            if (buf_ptr_r != '0)
            begin
              buf_ptr_r <= buf_ptr_r - PW'(1);
            end
            else if (repeat_mode)
            begin
              buf_ptr_r <= start_ptr_r;
            end
            busy_seen_r <= (buf_ptr_r == '0) && !repeat_mode;
            state_r     <= ST_POST;
          end
        end
        ST_POST:
        begin
          if (rise_e)
          begin
            post_cnt_r <= post_cnt_r + 2'h1;
            gap_cnt_r  <= gap_cnt_r + (GAP_W+1)'(1);
          end
          if (post_end && !serial_mode_reg_r[BIT_UNIT_ON])
          begin
            xfer_active_r <= 1'b0;
            resume_pend_r <= !busy_seen_r;
            state_r       <= ST_IDLE;
          end
          else if (post_end && busy_seen_r)
          begin
            xfer_active_r <= 1'b0;
            state_r       <= ST_IDLE;
          end
          // Busy at second rise holds off
          else if (post_end && busy_en && busy_act)
          begin
            state_r <= ST_BUSY;
          end
          else if (post_cnt_r >= POST_RISE && gap_ok && fall_e)
          begin
            state_r <= ST_LOAD;
          end
          else if (post_end && !gap_time_reg_r[BIT_GAP_ON])
          begin
            state_r <= ST_LOAD;
          end
          if (rise_e && post_cnt_r >= POST_RISE)
          begin
            post_cnt_r <= POST_RISE;
          end
        end
        ST_BUSY:
        begin
          if (fall_e && !busy_act)
          begin
            state_r <= ST_LOAD;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      xfer_done_flag_r <= 1'b0;
      err_r            <= 1'b0;
      o_xfer_done_irq  <= 1'b0;
    end
    else
    begin
      o_xfer_done_irq <= done_set && !i_halt;
      if (done_set && !i_halt)
      begin
        xfer_done_flag_r <= 1'b1;
      end
      else if (i_wr && i_addr == OFS_STATUS && i_wdata[BIT_DONE])
      begin
        xfer_done_flag_r <= 1'b0;
      end
      if (state_r == ST_SHIFT && fall_e && busy_en && busy_act)
      begin
        err_r <= 1'b1;
      end
      else if (i_wr && i_addr == OFS_AUTO && !i_wdata[BIT_ERR])
      begin
        err_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_serial_clk_pin <= 1'b1;
      o_serial_clk_oe  <= 1'b0;
      o_serial_out_pin <= 1'b0;
      o_serial_out_oe  <= 1'b0;
      o_pulse_out_pin  <= 1'b0;
      o_pulse_out_oe   <= 1'b0;
      o_port_mode      <= 1'b1;
    end
    else
    begin
      // Pins return to port when idle
      o_port_mode     <= !xfer_active_r;
      o_serial_out_oe <= xfer_active_r;
      o_serial_clk_oe <= xfer_active_r && serial_mode_reg_r[BIT_CLK_SRC];
      o_pulse_out_oe  <= xfer_active_r && serial_mode_reg_r[BIT_AUTO_ON]
                         && auto_ctrl_reg_r[BIT_PULSE_ON];
      o_serial_clk_pin <= (state_r == ST_SHIFT) ? int_phase_r : 1'b1;
      if (!xfer_active_r)
      begin
        o_serial_out_pin <= 1'b0;
      end
      else if (state_r == ST_SHIFT && fall_e)
      begin
        o_serial_out_pin <= shift_reg_r[7];
      end
      // Strobe from byte end to next rise
      if (byte_end && serial_mode_reg_r[BIT_AUTO_ON] && auto_ctrl_reg_r[BIT_PULSE_ON])
      begin
        o_pulse_out_pin <= 1'b1;
      end
      else if (rise_e || !xfer_active_r)
      begin
        o_pulse_out_pin <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_rd)
    begin
      case (i_addr)
        OFS_MODE:   o_rdata <= serial_mode_reg_r;
        OFS_AUTO:   o_rdata <= {auto_ctrl_reg_r[7:5], err_r, xfer_active_r,
                                auto_ctrl_reg_r[2:0]};
        OFS_GAP:    o_rdata <= gap_time_reg_r;
        OFS_PTR:    o_rdata <= 8'(buf_ptr_r);
        OFS_SHIFT:  o_rdata <= shift_reg_r;
        OFS_STATUS: o_rdata <= {7'h00, xfer_done_flag_r};
        default:    o_rdata <= buf_hit(i_addr) ? buf_mem_r[buf_idx(i_addr)] : 8'h00;
      endcase
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

endmodule

// File: ashc_slave.sv
// Purpose: Slave model with busy handshake
// Assumes: Data sampled on serial clock rises
// Notes:   Busy timed in ns, clock stands while waiting
`timescale 1ns/1ps
module ashc_slave
#(
  parameter int TSCK = 40
)
(
  // Serial pins
  input  wire logic       i_sclk,
  input  wire logic       i_sdata,
  input  wire logic       i_idle,
  // Model controls
  input  wire logic       i_pol,
  input  wire logic [7:0] i_hold,
  input  wire logic       i_mid_err,
  output logic            o_busy
);
  logic [7:0] sh_r;
  int         cnt_r;
  logic       act_r;
  logic [7:0] rx_q[$];

  initial act_r = 1'b0;
  // ****************************************
  // Byte capture and busy
  // ****************************************
  always @(posedge i_sclk or posedge i_idle)
  begin
    if (i_idle)
      cnt_r = 0;
    else
    begin
      sh_r = {sh_r[6:0], i_sdata};
      cnt_r = cnt_r + 1;
      if (cnt_r == 3 && i_mid_err)
      begin
        act_r = 1'b1;
        act_r <= #(TSCK) 1'b0;
      end
      if (cnt_r == 8)
      begin
        rx_q.push_back(sh_r);
        cnt_r = 0;
        if (i_hold != 8'h00)
        begin
          act_r = 1'b1;
          act_r <= #(i_hold * TSCK) 1'b0;
        end
      end
    end
  end
  assign o_busy = act_r ^ i_pol;
endmodule

// File: ashc_ctrl_checker.sv
// Purpose: Port assertions for the controller
// Assumes: Core clock domain only
// Notes:   Bound to every controller instance
`timescale 1ns/1ps
module ashc_ctrl_checker
  import ashc_pkg::*;
#(
  parameter logic [7:0] HALF_DIV = 8'h08
)
(
  // Clock, reset, inputs
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  input wire logic       i_rd,
  input wire logic       i_halt,
  // Outputs watched
  input wire logic [7:0] o_rdata,
  input wire logic       o_serial_clk_pin,
  input wire logic       o_serial_clk_oe,
  input wire logic       o_serial_out_pin,
  input wire logic       o_serial_out_oe,
  input wire logic       o_pulse_out_pin,
  input wire logic       o_pulse_out_oe,
  input wire logic       o_port_mode,
  input wire logic       o_xfer_done_irq
);
  int   since_r;
  logic seen_r;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // ****************************************
  // Strobe history
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      since_r <= 1000;
    else if (o_pulse_out_pin)
      since_r <= 0;
    else if (since_r < 1000)
      since_r <= since_r + 1;
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      seen_r <= 1'b0;
    else if (o_pulse_out_oe)
      seen_r <= 1'b1;
    else if (!o_port_mode)
      seen_r <= 1'b0;
  end

  sequence idle_s;
    o_port_mode && $past(o_port_mode);
  endsequence
  sequence strobe_hold_s;
    o_pulse_out_pin [*3];
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  idle_data_low_a: assert property (idle_s |-> !o_serial_out_pin)
    else $error("data high while idle");
  idle_pins_off_a: assert property (idle_s
    |-> !(o_serial_out_oe || o_serial_clk_oe || o_pulse_out_oe))
    else $error("pin driven in port mode");
  clk_idle_high_a: assert property (idle_s |-> o_serial_clk_pin)
    else $error("serial clock low while idle");
  halt_freeze_a: assert property (i_halt && $past(i_halt) && $past(i_halt, 2)
    |-> $stable(o_serial_clk_pin) && $stable(o_serial_out_pin))
    else $error("pins moved during halt");
  strobe_hold_a: assert property ($rose(o_pulse_out_pin) |-> strobe_hold_s)
    else $error("strobe too short");
  strobe_oe_a: assert property (o_pulse_out_pin |-> o_pulse_out_oe)
    else $error("strobe without enable");
  done_after_strobe_a: assert property (o_xfer_done_irq && seen_r
    |-> since_r <= 4 * int'(HALF_DIV) + 4)
    else $error("done without strobe");
  irq_single_a: assert property (o_xfer_done_irq |=> !o_xfer_done_irq)
    else $error("done pulse too long");
  rdata_zero_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
endmodule

bind ashc_ctrl ashc_ctrl_checker #(.HALF_DIV(HALF_DIV)) u_chk (.i_core_clk, .i_rst_n, .i_rd,
  .i_halt, .o_rdata, .o_serial_clk_pin, .o_serial_clk_oe, .o_serial_out_pin, .o_serial_out_oe,
  .o_pulse_out_pin, .o_pulse_out_oe, .o_port_mode, .o_xfer_done_irq);

// File: testbench.sv
// Purpose: Self-checking bench for the serial controller
// Assumes: Half divider 4, serial period 40 ns
// Notes:   Byte stream compared with a queue model
`timescale 1ns/1ps
module testbench
  import ashc_pkg::*;
;
  localparam int HD = 4;
  logic       i_core_clk, i_rst_n, i_wr, i_rd, i_halt, i_serial_clk_pin, i_busy_pin;
  logic [7:0] i_addr, i_wdata, o_rdata, v, hold, buf_m[32];
  logic       o_serial_clk_pin, o_serial_clk_oe, o_serial_out_pin, o_serial_out_oe;
  logic       o_pulse_out_pin, o_pulse_out_oe, o_port_mode, o_xfer_done_irq, pol, mid;
  int         mismatches, cmp_count, t0, t, n, n_stb;
  logic [7:0] exp_q[$];

  ashc_ctrl #(.HALF_DIV(8'(HD))) dut (.i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_halt, .i_serial_clk_pin, .o_serial_clk_pin, .o_serial_clk_oe,
    .o_serial_out_pin, .o_serial_out_oe, .o_pulse_out_pin, .o_pulse_out_oe, .i_busy_pin,
    .o_port_mode, .o_xfer_done_irq);
  ashc_slave #(.TSCK(10 * HD)) slv (
    .i_sclk(o_serial_clk_oe ? o_serial_clk_pin : i_serial_clk_pin),
    .i_sdata(o_serial_out_pin), .i_idle(o_port_mode), .i_pol(pol), .i_hold(hold),
    .i_mid_err(mid), .o_busy(i_busy_pin));

  initial
  begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge o_pulse_out_pin) n_stb++;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic finish_test();
  begin
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
  begin
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  end
  endtask
  task automatic wait_idle(output int c);
  begin
    c = 0;
    repeat (4) @(posedge i_core_clk);
    while (o_port_mode !== 1'b1)
    begin
      @(posedge i_core_clk);
      c++;
      if (c > 20000)
      begin
        mismatches++;
        finish_test();
      end
    end
  end
  endtask
  task automatic cmp_rx();
  begin
    while (slv.rx_q.size() > 0)
      chk(slv.rx_q.pop_front(), exp_q.pop_front());
    chk(8'(exp_q.size()), 8'h00);
    exp_q.delete();
  end
  endtask
  task automatic start(input logic [7:0] p);
  begin
    wr(OFS_PTR, p);
    for (int i = int'(p); i >= 0; i--)
      exp_q.push_back(buf_m[i]);
    wr(OFS_SHIFT, 8'($urandom));
  end
  endtask
  task automatic run(input logic [7:0] p, input int hdly, output int c);
  begin
    start(p);
    if (hdly > 0)
    begin
      repeat (hdly) @(posedge i_core_clk);
      i_halt <= 1'b1;
      repeat (40) @(posedge i_core_clk);
      i_halt <= 1'b0;
    end
    wait_idle(c);
    cmp_rx();
  end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {i_rst_n, i_wr, i_rd, i_halt, pol, mid, i_addr, i_wdata, hold} = '0;
    i_serial_clk_pin = 1'b1;
    v = 8'($urandom(32'h87F266BF));
    repeat (12) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      buf_m[i] = 8'($urandom);
      wr(OFS_BUF + 8'(4 * i), buf_m[i]);
    end
    rd(8'h7C, v);
    chk(v, 8'h00);
    wr(OFS_MODE, 8'hA2);
    run(8'h02, 0, t0);
    chk(8'(n_stb), 8'h00);
    rd(OFS_STATUS, v);
    chk(v, 8'h01);
    hold = 8'h0A;
    for (int p = 0; p < 2; p++)
    begin
      wr(OFS_STATUS, 8'h01);
      pol = p[0];
      n_stb = 0;
      wr(OFS_AUTO, {7'h00, pol} | 8'h06);
      run(8'h02, 0, t);
      chk(8'(t > t0 + 2 * (int'(hold) - 3) * 2 * HD), 8'h01);
      chk(8'(n_stb), 8'h03);
      rd(OFS_STATUS, v);
      chk(v, 8'h01);
    end
    pol = 1'b0;
    wr(OFS_AUTO, 8'h04);
    run(8'h02, 0, t);
    chk(8'(t < t0 + 48), 8'h01);
    wr(OFS_GAP, 8'h80);
    wr(OFS_AUTO, 8'h06);
    run(8'h02, 0, t);
    chk(8'(t < t0 + 48), 8'h01);
    wr(OFS_GAP, 8'h00);
    hold = 8'h00;
    mid = 1'b1;
    wr(OFS_AUTO, 8'h02);
    run(8'h00, 0, t);
    mid = 1'b0;
    rd(OFS_AUTO, v);
    chk(v & 8'h10, 8'h10);
    wr(OFS_AUTO, 8'h02);
    rd(OFS_AUTO, v);
    chk(v & 8'h10, 8'h00);
    wr(OFS_AUTO, 8'h00);
    run(8'h01, 20 + ($urandom % 40), t);
    start(8'h05);
    repeat (150) @(posedge i_core_clk);
    wr(OFS_MODE, 8'h22);
    wait_idle(t);
    rd(OFS_AUTO, v);
    chk(v & 8'h08, 8'h00);
    chk({7'h00, o_serial_out_pin}, 8'h00);
    chk(8'(slv.rx_q.size() inside {[1:5]}), 8'h01);
    wr(OFS_MODE, 8'hA2);
    wr(OFS_SHIFT, 8'($urandom));
    wait_idle(t);
    cmp_rx();
    wr(OFS_STATUS, 8'h01);
    wr(OFS_AUTO, 8'h20);
    wr(OFS_PTR, 8'h01);
    wr(OFS_SHIFT, 8'($urandom));
    for (int k = 0; k < 5000 && slv.rx_q.size() < 5; k++)
      @(posedge i_core_clk);
    wr(OFS_MODE, 8'h22);
    wait_idle(t);
    n = slv.rx_q.size();
    for (int i = 0; i < n; i++)
      exp_q.push_back(buf_m[1 - i % 2]);
    cmp_rx();
    chk(8'(n >= 5), 8'h01);
    rd(OFS_STATUS, v);
    chk(v, 8'h00);
    wr(OFS_AUTO, 8'h00);
    wr(OFS_MODE, 8'hA0);
    start(8'h00);
    #7;
    repeat (12)
    begin
      #32 i_serial_clk_pin = 1'b0;
      #32 i_serial_clk_pin = 1'b1;
      chk({7'h00, o_serial_clk_oe}, 8'h00);
    end
    wait_idle(t);
    cmp_rx();
    finish_test();
  end
endmodule
